// [psr_pkg.sv]
/*
 * psr_pkg: shared constants for the pressure readout slave.
 * assumes: one 40 MHz clock (ref_clk); every user of this package imports it whole.
 */
package psr_pkg;

    // ==================================================================
    // clock and refresh timing
    // ==================================================================
    localparam int CLK_PERIOD_NS   = 25;                              // ref_clk period
    localparam int REFRESH_TIME_NS = 250000;                          // 250 us refresh cycle
    localparam int REFRESH_CYCLES  = REFRESH_TIME_NS / CLK_PERIOD_NS; // nominal period, rounded down

    // ==================================================================
    // bus addressing
    // ==================================================================
    localparam logic [6:0] PRIMARY_ADDR   = 7'h78;    // fixed slave address 1111000
    localparam logic [6:0] SECOND_ADDR_RV = 7'h00;    // secondary address reset value
    localparam int         ADDR_RW_POS    = 0;        // direction bit inside the address byte
    localparam logic [2:0] LAST_BIT       = 3'h7;     // bit index of the eighth bit in a byte

    // ==================================================================
    // pressure code layout and correction
    // ==================================================================
    localparam int          ADC_BITS      = 12;        // raw conversion result resolution
    localparam int          WORD_BITS     = 15;        // pressure word carried on the bus
    localparam int          HI_BYTE_POS   = 8;         // low bit of the upper part of the word
    localparam logic [14:0] CODE_OFFSET   = 15'h0AAB;  // 2731 counts at lowest pressure
    localparam logic [14:0] CODE_SPAN_MUL = 15'h555A;  // scale so full code lands on 24575
    localparam int          SPAN_SHIFT    = 12;        // divide by 4096 after the multiply
    localparam logic [14:0] WORD_RESET    = CODE_OFFSET; // word shown before the first refresh

    // maps a 12-bit result onto the 15-bit output code (2731 .. 24575, mid code 2048 gives 13656)
    function automatic logic [14:0] psr_correct(input logic [11:0] code);
        logic [26:0] prod;
        prod = {15'h0000, code} * {12'h000, CODE_SPAN_MUL};
        return CODE_OFFSET + prod[26:SPAN_SHIFT];
    endfunction : psr_correct

endpackage : psr_pkg

// [psr_refresh.sv]
/*
 * psr_refresh: cyclic program that refreshes the corrected pressure word.
 * assumes: adcCode is a synchronous 12-bit result from the converter front end,
 * valid whenever it is sampled; bus activity has no influence here.
 */
`timescale 1ns/1ps
module psr_refresh
    import psr_pkg::*;
#(
    parameter int REFRESH_PERIOD = REFRESH_CYCLES   // cycles between refreshes
)(
    input  wire logic        ref_clk,      // 40 MHz clock
    input  wire logic        sys_rst,      // synchronous reset, active high
    input  wire logic [11:0] adcCode,      // raw conversion result
    output logic      [14:0] pressureWord, // corrected word held in the output register
    output logic             refreshPulse  // one cycle when the word was renewed
);

    // ==================================================================
    // period counter
    // ==================================================================
    logic [23:0] periodCnt;                                          // cycles since last refresh
    wire         periodEnd = (periodCnt == 24'(REFRESH_PERIOD - 1)); // last cycle of a period

    // free-running: a refresh never waits for the bus, so a reader may see a new word per read
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            periodCnt    <= 24'h00_0000;
            pressureWord <= WORD_RESET;
            refreshPulse <= 1'b0;
        end
        else
        begin
            periodCnt    <= periodEnd ? 24'h00_0000 : periodCnt + 24'h00_0001;
            refreshPulse <= periodEnd;
            if (periodEnd)
            begin
                // store the corrected value
                pressureWord <= psr_correct(adcCode);
            end
        end
    end

endmodule : psr_refresh

// [psr_readout.sv]
/*
 * psr_readout: read-only two-wire slave returning the pressure word.
 * assumes: sclIn/sdaIn are already synchronous to ref_clk and sampled fast
 * enough (40 MHz against at most 400 kHz) to see every edge; the wires are
 * resolved outside from the output enables, with pull-ups.
 */
// Notes on behaviour
// - word refreshed every 250 us, bus-independent
// - slave only, never starts a transfer
// - idle bus: both lines left released high
// - start condition begins a transfer
// - stop condition ends bus activity
// - repeated starts each answered without stop
// - data changed only while clock low
// - bytes of eight bits, MSB first
// - receiver acknowledges each byte with low
// - missing master ack: release, await start
// - answer fixed address 1111000 plus direction
// - optional secondary address also answered
// - address byte: 7 bits, direction bit
// - reads return two bytes of pressure
// - codes 2731 low, 24575 full, 13653 mid; psr_correct gives 13656 for mid input 2048
`timescale 1ns/1ps
module psr_readout
    import psr_pkg::*;
#(
    parameter int REFRESH_PERIOD = REFRESH_CYCLES   // shorten in simulation
)(
    input  wire logic        ref_clk,       // 40 MHz clock
    input  wire logic        sys_rst,       // synchronous reset, active high
    input  wire logic        sclIn,         // serial clock level
    output logic             sclOut,        // serial clock drive value, always low
    output logic             sclOe,         // serial clock enable, never asserted
    input  wire logic        sdaIn,         // serial data level
    output logic             sdaOut,        // serial data drive value, always low
    output logic             sdaOe,         // serial data pull-down enable
    input  wire logic [11:0] adcCode,       // raw conversion result
    input  wire logic        secondAddrEn,  // factory option: secondary address in use
    input  wire logic [6:0]  secondAddr,    // factory option: secondary address
    output logic [14:0]      pressureWord,  // current corrected word
    output logic             refreshPulse,  // word renewed this cycle
    output logic             busBusy        // between start and stop
);

    // ==================================================================
    // cyclic refresh of the output register
    // ==================================================================
    psr_refresh #(
        .REFRESH_PERIOD (REFRESH_PERIOD)
    ) uRefresh (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .adcCode      (adcCode),
        .pressureWord (pressureWord),
        .refreshPulse (refreshPulse)
    );

    // ==================================================================
    // line sampling and condition decode
    // ==================================================================
    logic sclPrev;   // clock level one cycle ago
    logic sdaPrev;   // data level one cycle ago

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            // released lines read high on an idle bus
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
        end
    end

    wire sclRise  = sclIn & ~sclPrev;                     // sample point of a bit
    wire sclFall  = ~sclIn & sclPrev;                     // change point of a bit
    wire startSeen = sclIn & sclPrev & sdaPrev & ~sdaIn;
    wire stopSeen  = sclIn & sclPrev & ~sdaPrev & sdaIn;

    // ==================================================================
    // transfer sequencer
    // ==================================================================
    typedef enum logic [2:0] {
        ST_IDLE,      // released, waiting for a start
        ST_ADDR,      // shifting in the address byte
        ST_ADDR_ACK,  // holding our address acknowledge
        ST_TX,        // shifting out a pressure byte
        ST_TX_ACK,    // master's acknowledge slot
        ST_RX,        // written bytes, taken and dropped
        ST_RX_ACK     // holding acknowledge for a written byte
    } psr_state_e;

    psr_state_e  state;       // sequencer state
    logic [2:0]  bitCnt;      // bits sampled in the current byte
    logic [7:0]  shiftIn;     // received bits
    logic [7:0]  shiftOut;    // bits still to send
    logic [14:0] snapWord;    // word frozen for the current read
    logic        byteSel;     // 0: upper byte being sent, 1: lower byte being sent
    logic        masterAck;   // master acknowledged the last byte
    logic        pullLow;     // drive data low
    logic        busByteFull; // eight bits taken in ST_ADDR / ST_RX
    logic        txByteFull;  // eight bits clocked out in ST_TX

    // address match on the byte completed by the last rising edge
    wire       dirRead   = shiftIn[ADDR_RW_POS];           // direction bit after the eighth sample
    wire       hitPrime  = (shiftIn[7:1] == PRIMARY_ADDR);
    wire       hitSecond = secondAddrEn & (shiftIn[7:1] == secondAddr);
    wire       addrHit   = hitPrime | hitSecond;
    wire [7:0] hiByte    = {1'b0, snapWord[14:HI_BYTE_POS]};
    wire [7:0] loByte    = snapWord[7:0];
    wire       byteDone  = (bitCnt == LAST_BIT);           // eighth sample this edge

    // the slave only ever follows master edges; nothing here starts a transfer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state     <= ST_IDLE;
            bitCnt    <= 3'h0;
            shiftIn   <= 8'h00;
            shiftOut  <= 8'h00;
            snapWord  <= WORD_RESET;
            byteSel   <= 1'b0;
            masterAck <= 1'b0;
            pullLow   <= 1'b0;
            busBusy   <= 1'b0;
        end
        else if (startSeen)
        begin
            // start or repeated start: always begin a fresh address byte
            state   <= ST_ADDR;
            bitCnt  <= 3'h0;
            pullLow <= 1'b0;
            busBusy <= 1'b1;
        end
        else if (stopSeen)
        begin
            // stop: release everything
            state   <= ST_IDLE;
            pullLow <= 1'b0;
            busBusy <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    // lines left alone until the next start
                    pullLow <= 1'b0;
                end
                ST_ADDR, ST_RX:
                begin
                    if (sclRise)
                    begin
                        // sample while clock is high, MSB arrives first
                        shiftIn <= {shiftIn[6:0], sdaIn};
                        bitCnt  <= bitCnt + 3'h1;
                    end
                    if (sclFall && bitCnt == 3'h0 && busByteFull)
                    begin
                        if (state == ST_RX || addrHit)
                        begin
                            // acknowledge during the ninth clock
                            pullLow <= 1'b1;
                            state   <= (state == ST_RX) ? ST_RX_ACK : ST_ADDR_ACK;
                            if (state == ST_ADDR)
                            begin
                                // freeze the word so both bytes belong together
                                snapWord <= pressureWord;
                            end
                        end
                        else
                        begin
                            // not our address: stay off the bus until the next start
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (sclFall)
                    begin
                        bitCnt <= 3'h0;
                        if (dirRead)
                        begin
                            // put the upper byte's first bit out while clock is low
                            state    <= ST_TX;
                            shiftOut <= {hiByte[6:0], 1'b0};
                            pullLow  <= ~hiByte[7];
                            byteSel  <= 1'b0;
                        end
                        else
                        begin
                            state   <= ST_RX;
                            pullLow <= 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclRise)
                        bitCnt <= bitCnt + 3'h1;
                    if (sclFall)
                    begin
                        if (txByteFull)
                        begin
                            // release for the master's acknowledge
                            state   <= ST_TX_ACK;
                            pullLow <= 1'b0;
                        end
                        else
                        begin
                            // next bit, MSB first, changed only in the low phase
                            shiftOut <= {shiftOut[6:0], 1'b0};
                            pullLow  <= ~shiftOut[7];
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (sclRise)
                        masterAck <= ~sdaIn;
                    if (sclFall)
                    begin
                        bitCnt <= 3'h0;
                        if (masterAck)
                        begin
                            // after the lower byte the sequence wraps to the upper byte
                            state    <= ST_TX;
                            shiftOut <= byteSel ? {hiByte[6:0], 1'b0} : {loByte[6:0], 1'b0};
                            pullLow  <= byteSel ? ~hiByte[7] : ~loByte[7];
                            byteSel  <= ~byteSel;
                        end
                        else
                        begin
                            // no acknowledge: go quiet, wait for start or stop
                            state   <= ST_IDLE;
                            pullLow <= 1'b0;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    if (sclFall)
                    begin
                        // written bytes carry no meaning for a read-only part
                        state   <= ST_RX;
                        bitCnt  <= 3'h0;
                        pullLow <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // byte-complete tracking
    // ==================================================================
    // bitCnt wraps to zero after the eighth sample; these flags tell a full byte from an empty one
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || startSeen || stopSeen)
        begin
            busByteFull <= 1'b0;
            txByteFull  <= 1'b0;
        end
        else
        begin
            if (sclRise && byteDone && (state == ST_ADDR || state == ST_RX))
                busByteFull <= 1'b1;
            else if (sclFall)
                busByteFull <= 1'b0;
            if (sclRise && byteDone && state == ST_TX)
                txByteFull <= 1'b1;
            else if (sclFall)
                txByteFull <= 1'b0;
        end
    end

    // ==================================================================
    // pin drivers
    // ==================================================================
    // open drain only: the value is low, the enable decides; clock is never driven
    assign sdaOut = 1'b0;
    assign sdaOe  = pullLow;
    assign sclOut = 1'b0;
    assign sclOe  = 1'b0;

endmodule : psr_readout

// [psr_readout_monitor.sv]
/*
 * psr_readout_monitor: port-level checks on the pressure readout slave.
 * assumes: bound to psr_readout; one clock, synchronous active-high reset held at least two edges.
 */
`timescale 1ns/1ps
module psr_readout_monitor
    import psr_pkg::*;
#(
    parameter int REFRESH_PERIOD = REFRESH_CYCLES   // handed on from the bound instance
)(
    input wire logic        ref_clk,      // 40 MHz clock
    input wire logic        sys_rst,      // synchronous reset
    input wire logic        sclIn,        // clock wire level
    input wire logic        sclOut,       // clock drive value
    input wire logic        sclOe,        // clock drive enable
    input wire logic        sdaIn,        // data wire level
    input wire logic        sdaOut,       // data drive value
    input wire logic        sdaOe,        // data pull-down enable
    input wire logic [11:0] adcCode,      // raw result
    input wire logic        secondAddrEn, // secondary address option
    input wire logic [6:0]  secondAddr,   // secondary address
    input wire logic [14:0] pressureWord, // corrected word
    input wire logic        refreshPulse, // word renewed
    input wire logic        busBusy       // start seen, no stop yet
);
    // ==================================================================
    // helper: cycles since the last refresh
    // ==================================================================
    logic [31:0] sinceRefresh; // cleared at each pulse
    logic        seenRefresh;  // first pulse has passed, spacing is defined from here

    // counter only; the first pulse is not judged since its phase after reset is a choice
    always_ff @(posedge ref_clk)
    begin
        sinceRefresh <= (sys_rst || refreshPulse) ? 32'h0000_0000 : sinceRefresh + 32'h0000_0001;
        seenRefresh  <= !sys_rst && (seenRefresh || refreshPulse);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ==================================================================
    // assertions
    // ==================================================================
    chk_scl_never_driven: assert property (!sclOe && !sclOut)
        else $error("clock line driven by slave");
    chk_sda_low_only: assert property (sdaOe |-> !sdaOut)
        else $error("data line driven high");
    chk_reset_state: assert property ($past(sys_rst) |-> !sdaOe && !busBusy && pressureWord == 15'h0AAB)
        else $error("wrong state after reset");
    chk_sda_hold_high: assert property ($past(sclIn) && sclIn |-> $stable(sdaOe))
        else $error("data changed in clock high phase");
    chk_oe_after_fall: assert property ($changed(sdaOe) |-> !$past(sclIn))
        else $error("data changed without clock low");
    chk_busy_on_start: assert property ($past(sclIn) && sclIn && $fell(sdaIn) |-> ##[1:2] busBusy)
        else $error("start not recognised");
    chk_free_on_stop: assert property ($past(sclIn) && sclIn && $rose(sdaIn) |-> ##[1:2] !busBusy)
        else $error("stop not recognised");
    chk_idle_released: assert property (!busBusy |-> !sdaOe)
        else $error("data pulled while bus idle");
    chk_refresh_period: assert property (seenRefresh |-> refreshPulse == (sinceRefresh == 32'(REFRESH_PERIOD - 1)))
        else $error("refresh spacing wrong");
    chk_word_held: assert property (!refreshPulse |-> $stable(pressureWord))
        else $error("word changed without refresh");
endmodule : psr_readout_monitor

bind psr_readout psr_readout_monitor #(.REFRESH_PERIOD(REFRESH_PERIOD)) psr_readout_monitor_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .adcCode(adcCode), .secondAddrEn(secondAddrEn),
    .secondAddr(secondAddr), .pressureWord(pressureWord), .refreshPulse(refreshPulse), .busBusy(busBusy));

// [psr_bus_master.sv]
/*
 * psr_bus_master: behavioural two-wire master that reads the sensor.
 * assumes: the bench resolves both wires with pull-ups; lines change at falling ref_clk edges.
 */
`timescale 1ns/1ps
module psr_bus_master #(
    parameter int HALF = 50   // cycles per clock phase: 100 per bit is 400 kHz
)(
    input  wire logic ref_clk, // bench clock
    input  wire logic sclLine, // resolved clock wire
    input  wire logic sdaLine, // resolved data wire
    output logic      sclLow,  // pull clock low
    output logic      sdaLow   // pull data low
);
    // both lines released at time zero, the bus starts idle
    initial
    begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hw

    // one edge of hold after the clock fell, so the slave never sees data and clock move together
    task automatic putBit(input logic b, output logic s);
        @(negedge ref_clk);
        sdaLow = !b;
        hw(HALF);
        sclLow = 1'b0;      // one pulse per bit
        hw(HALF / 2);
        s = sdaLine;
        hw(HALF - HALF / 2);
        sclLow = 1'b1;
    endtask : putBit

    // works from idle and as a repeated start with the clock low
    task automatic start();
        @(negedge ref_clk);
        sdaLow = 1'b0;
        hw(HALF);
        sclLow = 1'b0;
        hw(HALF);
        sdaLow = 1'b1;
        hw(HALF);
        sclLow = 1'b1;
    endtask : start

    task automatic stop();
        @(negedge ref_clk);
        sdaLow = 1'b1;
        hw(HALF);
        sclLow = 1'b0;
        hw(HALF);
        sdaLow = 1'b0;
        hw(HALF);
    endtask : stop

    // ackIn high: master pulls the ninth bit low; ackSeen: ninth bit read low
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackSeen);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            putBit(tx[i], s);
            rx[i] = s;
        end
        putBit(!ackIn, s);
        ackSeen = !s;
    endtask : xfer
endmodule : psr_bus_master

// [tb_psr_readout.sv]
/*
 * tb_psr_readout: self-checking bench for the pressure readout slave.
 * assumes: psr_bus_master as far side; refresh period shortened to 20 cycles.
 */
`timescale 1ns/1ps
module tb_psr_readout
    import psr_pkg::*;
;
    localparam int PERIOD = 20;   // short refresh so runs stay brief

    logic        ref_clk, sys_rst, secondAddrEn, sclOut, sclOe, sdaOut, sdaOe, refreshPulse, busBusy;
    logic        mScl, mSda;      // master pull-downs
    logic [11:0] adcCode;
    logic [6:0]  secondAddr;
    logic [14:0] pressureWord;
    int          errors, n_compared;
    wire         sclLine = !(mScl || sclOe);  // open drain with pull-up
    wire         sdaLine = !(mSda || sdaOe);

    psr_readout #(.REFRESH_PERIOD(PERIOD)) psr_readout_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .adcCode(adcCode), .secondAddrEn(secondAddrEn), .secondAddr(secondAddr),
        .pressureWord(pressureWord), .refreshPulse(refreshPulse), .busBusy(busBusy));
    psr_bus_master psr_bus_master_inst (.ref_clk(ref_clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclLow(mScl), .sdaLow(mSda));

    // ==================================================================
    // helpers
    // ==================================================================
    task automatic check(input string name, input logic [14:0] exp, input logic [14:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : check

    task automatic close_out();
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // two pulses, so the word reflects the code set before the first
    task automatic t_refresh(input logic [11:0] code, input logic [14:0] word);
        int n;
        adcCode = code;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            @(negedge ref_clk);
            while (refreshPulse !== 1'b1 && n < 3 * PERIOD)
            begin
                @(negedge ref_clk);
                n++;
            end
        end
        check("refresh pulse", 15'h0001, {14'h0000, refreshPulse});
        check("corrected word", word, pressureWord);
    endtask : t_refresh

    // one read frame; word is what the sensor should hold
    task automatic readAt(input logic [6:0] addr, input logic expAck, input logic [14:0] word);
        logic [7:0] rx;
        logic       ak;
        psr_bus_master_inst.start();
        psr_bus_master_inst.xfer({addr, 1'b1}, 1'b0, rx, ak);
        check("address ack", {14'h0000, expAck}, {14'h0000, ak});
        check("busy", 15'h0001, {14'h0000, busBusy});
        if (expAck)
        begin
            psr_bus_master_inst.xfer(8'hFF, 1'b1, rx, ak);
            check("upper byte", {7'h00, 1'b0, word[14:8]}, {7'h00, rx});
            psr_bus_master_inst.xfer(8'hFF, 1'b0, rx, ak);
            check("lower byte", {7'h00, word[7:0]}, {7'h00, rx});
            check("released on nack", 15'h0000, {14'h0000, ak});
        end
    endtask : readAt

    task automatic t_idle();
        psr_bus_master_inst.stop();
        check("busy after stop", 15'h0000, {14'h0000, busBusy});
        check("idle lines", 15'h0003, {13'h0000, sclLine, sdaLine});
    endtask : t_idle

    // ==================================================================
    // scenarios
    // ==================================================================
    task automatic t_write_dir();
        logic [7:0] rx;
        logic       ak;
        psr_bus_master_inst.start();
        psr_bus_master_inst.xfer({PRIMARY_ADDR, 1'b0}, 1'b0, rx, ak);
        check("write address ack", 15'h0001, {14'h0000, ak});
        psr_bus_master_inst.xfer(8'h12, 1'b0, rx, ak);
        check("write data ack", 15'h0001, {14'h0000, ak});
        t_idle();
    endtask : t_write_dir

    // master refuses the upper byte: the slave must stay off the line
    task automatic t_early_nack();
        logic [7:0] rx;
        logic       ak;
        psr_bus_master_inst.start();
        psr_bus_master_inst.xfer({PRIMARY_ADDR, 1'b1}, 1'b0, rx, ak);
        psr_bus_master_inst.xfer(8'hFF, 1'b0, rx, ak);
        psr_bus_master_inst.xfer(8'hFF, 1'b1, rx, ak);
        check("line after nack", 15'h00FF, {7'h00, rx});
        t_idle();
    endtask : t_early_nack

    // ==================================================================
    // clock, watchdog, main sequence
    // ==================================================================
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // 9 frames of under 3000 cycles each, about 22600 cycles in all, fit well inside this
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        close_out();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        adcCode = 12'h000;
        secondAddrEn = 1'b0;
        secondAddr = 7'h00;
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        check("reset word", 15'h0AAB, pressureWord);
        check("reset drive", 15'h0000, {13'h0000, sdaOe, busBusy});
        t_refresh(12'hFFF, 15'h5FFF);
        t_refresh(12'h000, 15'h0AAB);
        readAt(PRIMARY_ADDR, 1'b1, 15'h0AAB);
        t_idle();
        readAt(7'h55, 1'b0, 15'h0AAB);
        t_idle();
        secondAddrEn = 1'b1;
        secondAddr = 7'h2A;
        readAt(7'h2A, 1'b1, 15'h0AAB);
        readAt(PRIMARY_ADDR, 1'b1, 15'h0AAB);
        t_idle();
        secondAddrEn = 1'b0;
        readAt(7'h2A, 1'b0, 15'h0AAB);
        t_idle();
        t_refresh(12'hFFF, 15'h5FFF);
        readAt(PRIMARY_ADDR, 1'b1, 15'h5FFF);
        readAt(PRIMARY_ADDR, 1'b1, 15'h5FFF);
        t_idle();
        t_write_dir();
        t_early_nack();
        close_out();
    end
endmodule : tb_psr_readout
